// ==== src/alarm_output_option_control.sv ====
// Alarm panel option logic: pin roles, dialer setup, bells, aux relay, bypass authority
`timescale 1ns/1ps
module alarm_output_option_control import alarm_opt_pkg::*; #(
	parameter int SEC_DIV = SEC_CYCLES,
	parameter int DING_LEN = DING_CYCLES,
	parameter int MAX_ATTEMPTS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fire_alarm,
	input wire logic audible_alarm,
	input wire logic code_off,
	input wire logic keypad_aux_silence,
	input wire logic trouble_supv,
	input wire logic smoke_reset,
	input wire logic battery_save,
	input wire logic exit_delay_end,
	input wire logic closing_report,
	input wire logic kissoff,
	input wire logic chime_event,
	input wire logic [1:0] arm_partition,
	input wire logic arm_req,
	input wire logic [6:0] bypass_zone_type,
	input wire logic [9:0] bypass_zone_num,
	input wire logic [1:0] bypass_partition,
	input wire logic bypass_by_installer,
	input wire logic bypass_by_master,
	output logic printer_pins_en,
	output logic long_range_radio_outputs_full,
	output logic long_range_radio_outputs_limited,
	output logic long_range_radio_outputs_fire_only,
	output logic remote_sounder_en,
	output logic keyswitch_led_en,
	output logic led_annunciator_en,
	output logic [3:0] dial_attempts_max,
	output logic main_dialer_en,
	output logic backup_dialer_en,
	output logic backup_tone_dial,
	output logic [2:0] restore_report_en,
	output logic bell1_on,
	output logic bell2_on,
	output logic aux_relay_on,
	output logic arm_allowed,
	output logic bypass_allowed,
	output logic irq
);
	initial begin
		if (MAX_ATTEMPTS < 1 || MAX_ATTEMPTS > 8) $error("MAX_ATTEMPTS out of range");
	end

	logic [31:0] cfg0_reg;
	logic [31:0] cfg1_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_have_reg;
	logic w_have_reg;
	ax_state_e rd_state_reg;
	logic fire_latch_reg;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// Address and data may come in either order; write fires when both are held
	logic wr_fire;
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_reg)
					OFF_CFG0, OFF_CFG1, OFF_IRQ_EN, OFF_IRQ_CLR: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Attempt count is clamped so a bad write cannot leave zero or above the limit
	logic [31:0] cfg0_w;
	logic [3:0] att_w;
	always_comb begin
		cfg0_w = merge(cfg0_reg, wdata_reg, wstrb_reg);
		att_w = cfg0_w[F_ATT_LO +: 4];
		if (att_w == 4'h0) att_w = 4'h1;
		if (att_w > 4'(MAX_ATTEMPTS)) att_w = 4'(MAX_ATTEMPTS);
		cfg0_w[F_ATT_LO +: 4] = att_w;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg0_reg <= CFG0_RESET;
			cfg1_reg <= CFG1_RESET;
			irq_en_reg <= '0;
		end else if (wr_fire) begin
			case (awaddr_reg)
				OFF_CFG0: cfg0_reg <= cfg0_w;
				OFF_CFG1: cfg1_reg <= merge(cfg1_reg, wdata_reg, wstrb_reg);
				OFF_IRQ_EN: irq_en_reg <= IRQ_W'(merge(32'(irq_en_reg), wdata_reg, wstrb_reg));
				default: ;
			endcase
		end
	end

	// Read channel
	assign s_axi_arready = (rd_state_reg == AXS_IDLE);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= AXS_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end else begin
			case (rd_state_reg)
				AXS_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_reg <= AXS_RESP;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= 2'b00;
						case (s_axi_araddr)
							OFF_CFG0: s_axi_rdata <= cfg0_reg;
							OFF_CFG1: s_axi_rdata <= cfg1_reg;
							OFF_STATUS: s_axi_rdata <= {26'h0, arm_allowed, bypass_allowed,
								aux_relay_on, bell2_on, bell1_on, fire_latch_reg};
							OFF_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_reg);
							OFF_IRQ_EN: s_axi_rdata <= 32'(irq_en_reg);
							OFF_IRQ_CLR: s_axi_rdata <= 32'h0;
							default: begin
								s_axi_rdata <= 32'h0;
								s_axi_rresp <= 2'b10;
							end
						endcase
					end
				end
				AXS_RESP: begin
					if (s_axi_rready) begin
						rd_state_reg <= AXS_IDLE;
						s_axi_rvalid <= 1'b0;
					end
				end
				default: rd_state_reg <= AXS_IDLE;
			endcase
		end
	end

	// Static option decoding
	logic [1:0] trig_sel;
	logic [2:0] aux_sel;
	logic [1:0] byp_sel;
	assign trig_sel = cfg0_reg[F_TRIG_LO +: 2];
	assign aux_sel = cfg0_reg[F_AUXSEL_LO +: 3];
	assign byp_sel = cfg0_reg[F_BYP_LO +: 2];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			printer_pins_en <= 1'b0;
			long_range_radio_outputs_full <= 1'b0;
			long_range_radio_outputs_limited <= 1'b0;
			long_range_radio_outputs_fire_only <= 1'b0;
			remote_sounder_en <= 1'b0;
			keyswitch_led_en <= 1'b0;
			led_annunciator_en <= 1'b0;
			dial_attempts_max <= 4'h8;
			main_dialer_en <= 1'b0;
			backup_dialer_en <= 1'b0;
			backup_tone_dial <= 1'b0;
			restore_report_en <= 3'h0;
		end else begin
			printer_pins_en <= cfg0_reg[F_AUX_ALT];
			// Printer role takes the two shared pins away from the sounder, keyswitch LED and annunciator roles; radio outputs stay
			long_range_radio_outputs_full <= trig_sel == 2'h0;
			remote_sounder_en <= !cfg0_reg[F_AUX_ALT] && trig_sel == 2'h0;
			long_range_radio_outputs_limited <= trig_sel == 2'h1;
			keyswitch_led_en <= !cfg0_reg[F_AUX_ALT] && trig_sel == 2'h1;
			long_range_radio_outputs_fire_only <= trig_sel == 2'h2;
			led_annunciator_en <= !cfg0_reg[F_AUX_ALT] && trig_sel == 2'h2;
			dial_attempts_max <= cfg0_reg[F_ATT_LO +: 4];
			main_dialer_en <= cfg0_reg[F_DIAL_MAIN];
			backup_dialer_en <= cfg0_reg[F_DIAL_BACK];
			backup_tone_dial <= cfg0_reg[F_BACK_TONE];
			restore_report_en <= cfg0_reg[F_RESTORE_LO +: 3];
		end
	end

	// Bell 1 and fire silencing
	logic [1:0] off_cnt_reg;
	logic b1_fire_reg;
	logic b2_sil_fire;
	logic b1_sil_fire;
	assign b1_sil_fire = code_off && fire_latch_reg &&
		(!cfg0_reg[F_B1_SECOND] || off_cnt_reg != 2'h0);
	assign b2_sil_fire = code_off && fire_latch_reg &&
		(!cfg0_reg[F_B2_SECOND] || off_cnt_reg != 2'h0);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fire_latch_reg <= 1'b0;
			off_cnt_reg <= 2'h0;
			b1_fire_reg <= 1'b0;
		end else if (fire_alarm) begin
			fire_latch_reg <= 1'b1;
			off_cnt_reg <= 2'h0;
			b1_fire_reg <= 1'b1;
		end else if (code_off && fire_latch_reg) begin
			if (b1_sil_fire) b1_fire_reg <= 1'b0;
			if (off_cnt_reg != 2'h0) fire_latch_reg <= 1'b0;
			off_cnt_reg <= 2'h1;
		end
	end
	logic b1_burg_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) b1_burg_reg <= 1'b0;
		else if (audible_alarm) b1_burg_reg <= 1'b1;
		else if (code_off) b1_burg_reg <= 1'b0;
	end
	assign bell1_on = b1_fire_reg || b1_burg_reg;

	// Arming ding waits for kissoff when closings are reported
	logic ding_pend_reg;
	logic ding_now;
	assign ding_now = (exit_delay_end && !closing_report) || (ding_pend_reg && kissoff);
	always_ff @(posedge aclk) begin
		if (!aresetn) ding_pend_reg <= 1'b0;
		else if (exit_delay_end && closing_report) ding_pend_reg <= 1'b1;
		else if (kissoff) ding_pend_reg <= 1'b0;
	end

	// Aux relay source selection
	logic aux_start;
	logic aux_sil;
	always_comb begin
		aux_start = 1'b0;
		aux_sil = 1'b0;
		case (aux_sel)
			3'h0: aux_start = trouble_supv;
			3'h1: begin
				aux_start = audible_alarm || fire_alarm;
				aux_sil = code_off;
			end
			3'h2: aux_start = smoke_reset;
			3'h3: aux_start = battery_save;
			3'h4: begin
				aux_start = audible_alarm || fire_alarm;
				aux_sil = keypad_aux_silence;
			end
			default: ;
		endcase
	end

	logic tick;
	logic b2_exp;
	logic aux_exp;
	sec_tick #(.DIV(SEC_DIV)) u_tick (.aclk(aclk), .aresetn(aresetn), .tick(tick));
	out_timer #(.DING_LEN(DING_LEN)) u_b2 (.aclk(aclk), .aresetn(aresetn), .sec_tick(tick),
		.timeout_units(cfg1_reg[F_TO_B2_LO +: 4]), .alarm_start(audible_alarm || fire_alarm),
		.silence(b2_sil_fire || (code_off && !fire_latch_reg)),
		.ding_req(ding_now && cfg0_reg[F_DING_B2]),
		.chime_req(chime_event), .chime_en(cfg0_reg[F_CHIME_B2]),
		.out_on(bell2_on), .expired(b2_exp));
	out_timer #(.DING_LEN(DING_LEN)) u_aux (.aclk(aclk), .aresetn(aresetn), .sec_tick(tick),
		.timeout_units(cfg1_reg[F_TO_AUX_LO +: 4]), .alarm_start(aux_start),
		.silence(aux_sil), .ding_req(ding_now && cfg0_reg[F_DING_AUX]),
		.chime_req(chime_event), .chime_en(cfg0_reg[F_CHIME_AUX]),
		.out_on(aux_relay_on), .expired(aux_exp));

	// Partition one burglary gate and bypass authority
	logic fire_zone;
	logic sys_zone;
	assign fire_zone = bypass_zone_type == 7'd9 || (bypass_zone_type >= 7'd16 && bypass_zone_type <= 7'd18);
	assign sys_zone = bypass_zone_num >= 10'd970 && bypass_zone_num <= 10'd977;
	always_comb begin
		arm_allowed = arm_req && (arm_partition != 2'h1 || cfg0_reg[F_BURG_P1]);
		bypass_allowed = bypass_by_installer || bypass_by_master;
		if (bypass_partition == 2'h1 && (fire_zone || sys_zone)) begin
			case (byp_sel)
				2'h0: bypass_allowed = 1'b0;
				2'h1: bypass_allowed = bypass_by_installer;
				2'h2: bypass_allowed = bypass_by_installer || bypass_by_master;
				default: bypass_allowed = 1'b0;
			endcase
		end
	end

	// Events: fire alarm, bell 2 expiry, aux expiry, refused bypass; set beats clear
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] clr;
	assign ev = {(bypass_by_installer || bypass_by_master) && !bypass_allowed, aux_exp, b2_exp, fire_alarm};
	assign clr = (wr_fire && awaddr_reg == OFF_IRQ_CLR && wstrb_reg[0]) ? wdata_reg[IRQ_W-1:0] : '0;
	always_ff @(posedge aclk) begin
		if (!aresetn) irq_stat_reg <= '0;
		else irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
	end
	assign irq = |(irq_stat_reg & irq_en_reg);
endmodule

// ==== src/alarm_opt_pkg.sv ====
// Package of offsets, field positions, reset values and timing for the alarm option block
package alarm_opt_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int DING_MS = 500;
	localparam int TIMEOUT_UNIT_S = 120;
	localparam int DING_CYCLES = CLK_HZ / 1000 * DING_MS;
	localparam int SEC_CYCLES = CLK_HZ;
	localparam logic [11:0] OFF_CFG0 = 12'h000;
	localparam logic [11:0] OFF_CFG1 = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h00c;
	localparam logic [11:0] OFF_IRQ_EN = 12'h010;
	localparam logic [11:0] OFF_IRQ_CLR = 12'h014;
	localparam int F_AUX_ALT = 0;
	localparam int F_TRIG_LO = 1;
	localparam int F_ATT_LO = 3;
	localparam int F_DIAL_MAIN = 7;
	localparam int F_DIAL_BACK = 8;
	localparam int F_BACK_TONE = 9;
	localparam int F_RESTORE_LO = 10;
	localparam int F_B1_SECOND = 13;
	localparam int F_B2_SECOND = 14;
	localparam int F_DING_B2 = 15;
	localparam int F_DING_AUX = 16;
	localparam int F_CHIME_B2 = 17;
	localparam int F_CHIME_AUX = 18;
	localparam int F_AUXSEL_LO = 19;
	localparam int F_BURG_P1 = 22;
	localparam int F_BYP_LO = 23;
	localparam int F_TO_B2_LO = 0;
	localparam int F_TO_AUX_LO = 4;
	localparam logic [31:0] CFG0_RESET = 32'h00c8_00c0;
	localparam logic [31:0] CFG1_RESET = 32'h0000_0000;
	localparam int IRQ_W = 4;
	typedef enum logic [1:0] {
		AXS_IDLE = 2'b00,
		AXS_RESP = 2'b01
	} ax_state_e;
endpackage

// ==== src/sec_tick.sv ====
// Divider that gives a one-cycle pulse every second
`timescale 1ns/1ps
module sec_tick import alarm_opt_pkg::*; #(
	parameter int DIV = SEC_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);
	initial begin
		if (DIV < 2) $error("DIV too small");
	end
	logic [31:0] cnt_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_reg == 32'(DIV - 1));
			cnt_reg <= (cnt_reg == 32'(DIV - 1)) ? '0 : cnt_reg + 32'h1;
		end
	end
endmodule

// ==== src/out_timer.sv ====
// Timed output: alarm duration in two-minute units, ding pulse, chime, silence
`timescale 1ns/1ps
module out_timer import alarm_opt_pkg::*; #(
	parameter int DING_LEN = DING_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sec_tick,
	input wire logic [3:0] timeout_units,
	input wire logic alarm_start,
	input wire logic silence,
	input wire logic ding_req,
	input wire logic chime_req,
	input wire logic chime_en,
	output logic out_on,
	output logic expired
);
	initial begin
		if (DING_LEN < 1) $error("DING_LEN too small");
	end
	logic alarm_reg;
	logic [11:0] secs_reg;
	logic [31:0] ding_reg;
	logic [11:0] limit;
	assign limit = 12'(timeout_units) * 12'(TIMEOUT_UNIT_S);
	// Zero units means no limit, output stays until silenced
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_reg <= 1'b0;
			secs_reg <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (alarm_start) begin
				alarm_reg <= 1'b1;
				secs_reg <= '0;
			end else if (silence) begin
				alarm_reg <= 1'b0;
			end else if (alarm_reg && sec_tick) begin
				if (limit != 12'h000 && secs_reg + 12'h1 >= limit) begin
					alarm_reg <= 1'b0;
					expired <= 1'b1;
				end
				secs_reg <= secs_reg + 12'h1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ding_reg <= '0;
		end else if (ding_req || (chime_req && chime_en)) begin
			ding_reg <= 32'(DING_LEN);
		end else if (ding_reg != '0) begin
			ding_reg <= ding_reg - 32'h1;
		end
	end
	assign out_on = alarm_reg || (ding_reg != '0);
endmodule

// ==== sim/field_model.sv ====
// Far-side model: keypad, zones and central station raising event pulses
`timescale 1ns/1ps
module field_model (
	input wire logic aclk,
	input wire logic go,
	input wire logic [3:0] sel,
	input wire logic closing_report,
	output logic fire_alarm,
	output logic audible_alarm,
	output logic code_off,
	output logic keypad_aux_silence,
	output logic trouble_supv,
	output logic smoke_reset,
	output logic battery_save,
	output logic exit_delay_end,
	output logic chime_event,
	output logic kissoff
);
	logic [8:0] ev_reg = 9'h0;
	logic [3:0] kiss_reg = 4'h0;
	logic kissoff_reg = 1'b0;
	// Every event is a single-cycle pulse
	always_ff @(posedge aclk) begin
		ev_reg <= go ? 9'h1 << sel : 9'h0;
	end
	// Station acknowledges closings late, so the ding must wait for it
	always_ff @(posedge aclk) begin
		kiss_reg <= (exit_delay_end && closing_report) ? 4'h6 : (kiss_reg == 4'h0 ? 4'h0 : kiss_reg - 4'h1);
		kissoff_reg <= kiss_reg == 4'h1;
	end
	assign {chime_event, exit_delay_end, battery_save, smoke_reset, trouble_supv, keypad_aux_silence, code_off,
		audible_alarm, fire_alarm} = ev_reg;
	assign kissoff = kissoff_reg;
endmodule

// ==== sim/alarm_opt_chk_sva.sv ====
// Checker of port relations for the alarm option block
`timescale 1ns/1ps
module alarm_opt_chk import alarm_opt_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic printer_pins_en,
	input wire logic long_range_radio_outputs_full,
	input wire logic long_range_radio_outputs_limited,
	input wire logic long_range_radio_outputs_fire_only,
	input wire logic remote_sounder_en,
	input wire logic [3:0] dial_attempts_max,
	input wire logic [1:0] arm_partition,
	input wire logic arm_req,
	input wire logic arm_allowed,
	input wire logic [6:0] bypass_zone_type,
	input wire logic [1:0] bypass_partition,
	input wire logic bypass_by_installer,
	input wire logic bypass_by_master,
	input wire logic bypass_allowed
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
	property p_rdata_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read answer not held");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_radio_roles;
		$onehot0({long_range_radio_outputs_full, long_range_radio_outputs_limited, long_range_radio_outputs_fire_only});
	endproperty
	a_radio_roles: assert property (p_radio_roles) else $error("radio roles overlap");
	property p_printer_pins;
		printer_pins_en |-> !remote_sounder_en;
	endproperty
	a_printer_pins: assert property (p_printer_pins) else $error("printer and sounder together");
	property p_attempts;
		dial_attempts_max inside {[4'h1:4'h8]};
	endproperty
	a_attempts: assert property (p_attempts) else $error("attempts out of range");
	property p_other_arm;
		arm_req && arm_partition == 2'h2 |-> arm_allowed;
	endproperty
	a_other_arm: assert property (p_other_arm) else $error("arming refused off partition one");
	property p_bypass_nocode;
		bypass_partition == 2'h1 && bypass_zone_type == 7'h9 && !bypass_by_installer && !bypass_by_master
			|-> !bypass_allowed;
	endproperty
	a_bypass_nocode: assert property (p_bypass_nocode) else $error("fire bypass without code");
endmodule
bind alarm_output_option_control alarm_opt_chk u_chk (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench of the alarm option block
`timescale 1ns/1ps
module tb_top import alarm_opt_pkg::*;;
	logic aclk = 0, aresetn = 0, go = 0, closing_report = 0, arm_req = 0, bypass_by_installer = 0;
	logic bypass_by_master = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, hit;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rnd = 32'h0001_47bb, rd_data, c;
	logic [3:0] s_axi_wstrb = 4'hf, sel = 0;
	logic [1:0] arm_partition = 0, bypass_partition = 0, rd_resp, wr_resp;
	logic [6:0] bypass_zone_type = 0;
	logic [9:0] bypass_zone_num = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fire_alarm, audible_alarm, code_off;
	wire keypad_aux_silence, trouble_supv, smoke_reset, battery_save, exit_delay_end, kissoff, chime_event;
	wire printer_pins_en, long_range_radio_outputs_full, long_range_radio_outputs_limited, remote_sounder_en;
	wire long_range_radio_outputs_fire_only, keyswitch_led_en, led_annunciator_en, main_dialer_en, backup_dialer_en;
	wire backup_tone_dial, bell1_on, bell2_on, aux_relay_on, arm_allowed, bypass_allowed, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] dial_attempts_max;
	wire [2:0] restore_report_en;
	wire [17:0] pins = {printer_pins_en, long_range_radio_outputs_full, long_range_radio_outputs_limited,
		long_range_radio_outputs_fire_only, remote_sounder_en, keyswitch_led_en, led_annunciator_en,
		dial_attempts_max, main_dialer_en, backup_dialer_en, backup_tone_dial, restore_report_en};
	int errors = 0, tests_run = 0, cyc = 0, s, v, k;
	int src[5] = '{4, 1, 5, 6, 1};
	// Short divider and ding so two-minute units fit the run
	alarm_output_option_control #(.SEC_DIV(10), .DING_LEN(5)) uut (.*);
	field_model far (.*);
	always #2 aclk = ~aclk;
	function logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function logic [17:0] exp_cfg(logic [31:0] d);
		logic [1:0] t;
		logic [3:0] a;
		t = d[2:1];
		a = d[6:3] == 4'h0 ? 4'h1 : (d[6:3] > 4'h8 ? 4'h8 : d[6:3]);
		return {d[0], t == 2'h0, t == 2'h1, t == 2'h2, !d[0] && t == 2'h0, !d[0] && t == 2'h1, !d[0] && t == 2'h2,
			a, d[7], d[8], d[9], d[12:10]};
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task rst;
		@(posedge aclk);
		aresetn <= 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// Catches pulses too short to see at one sampling point
	task obs(input int n);
		hit = 0;
		repeat (n) begin
			@(negedge aclk);
			hit = hit | bell2_on;
		end
	endtask
	task ev(input logic [3:0] e);
		@(posedge aclk);
		sel <= e;
		go <= 1;
		@(posedge aclk);
		go <= 0;
		obs(3);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			close_out;
		end
	end
	initial begin
		rst;
		rd(OFF_CFG0);
		chk("cfg0", 32'h00c8_00c0, rd_data);
		chk("pins", exp_cfg(32'h00c8_00c0), pins);
		rd(12'h100);
		chk("resp", 32'h2, rd_resp);
		wr(12'h100, 32'h0);
		chk("bresp", 32'h2, wr_resp);
		for (s = 0; s < 8; s++) begin
			rnd = lfsr(rnd);
			c = s == 0 ? 32'h0 : (s == 1 ? 32'h7d : rnd & 32'h1fff);
			if (c[2:1] == 2'h3) c[2:1] = 2'h2;
			wr(OFF_CFG0, c);
			chk("bresp", 32'h0, wr_resp);
			obs(2);
			chk("pins", exp_cfg(c), pins);
		end
		for (v = 0; v < 3; v++) begin
			wr(OFF_CFG0, (32'(v) << 23) | (32'(v % 2) << 22));
			for (k = 0; k < 12; k++) begin
				@(posedge aclk);
				bypass_partition <= k % 4 == 3 ? 2'h2 : 2'h1;
				bypass_zone_type <= k % 3 == 0 ? 7'h9 : (k % 3 == 1 ? 7'h10 : 7'h0);
				bypass_zone_num <= k % 3 == 2 ? 10'h3d1 : 10'h5;
				bypass_by_installer <= (k / 3) % 2;
				bypass_by_master <= k / 6;
				arm_partition <= 1 + k % 2;
				arm_req <= 1;
				@(negedge aclk);
				chk("byp", (bypass_partition == 2'h2 || v == 2) ? (bypass_by_installer || bypass_by_master)
					: (v == 1 && bypass_by_installer), bypass_allowed);
				chk("arm", arm_partition == 2'h2 || v == 1, arm_allowed);
			end
		end
		rst;
		wr(OFF_IRQ_EN, 32'h1);
		wr(OFF_CFG0, 32'h00c8_20c0);
		ev(0);
		chk("bells", 32'h7, {bell1_on, bell2_on, irq});
		ev(2);
		chk("bells", 32'h5, {bell1_on, bell2_on, irq});
		ev(2);
		chk("bells", 32'h1, {bell1_on, bell2_on, irq});
		wr(OFF_IRQ_CLR, 32'h1);
		wr(OFF_IRQ_EN, 32'h0);
		ev(0);
		chk("irq", 32'h0, irq);
		rd(OFF_IRQ_STAT);
		chk("stat", 32'h1, rd_data & 32'h1);
		rd(OFF_STATUS);
		chk("status", 32'h3f, rd_data);
		rst;
		wr(OFF_CFG0, 32'h00c8_00c0);
		wr(OFF_CFG1, 32'h21);
		ev(1);
		obs(1140);
		chk("tmo", 32'h3, {bell2_on, aux_relay_on});
		obs(100);
		chk("tmo", 32'h1, {bell2_on, aux_relay_on});
		obs(1200);
		chk("tmo", 32'h0, {bell2_on, aux_relay_on});
		rd(OFF_IRQ_STAT);
		chk("stat", 32'h6, rd_data & 32'h7);
		for (s = 0; s < 5; s++) begin
			rst;
			wr(OFF_CFG0, 32'h00c0_00c0 | (32'(s) << 19));
			ev(s < 2 ? 5 : 4);
			chk("aux", 32'h0, aux_relay_on);
			ev(src[s]);
			chk("aux", 32'h1, aux_relay_on);
			if (s == 1 || s == 4) begin
				ev(2);
				chk("aux", s == 4, aux_relay_on);
				ev(3);
				chk("aux", 32'h0, aux_relay_on);
			end
		end
		rst;
		wr(OFF_CFG0, 32'h00c8_80c0);
		ev(7);
		chk("ding", 32'h1, hit);
		obs(10);
		chk("ding", 32'h0, bell2_on);
		@(posedge aclk);
		closing_report <= 1;
		ev(7);
		chk("ding", 32'h0, hit);
		obs(10);
		chk("ding", 32'h1, hit);
		wr(OFF_CFG0, 32'h00c8_00c0);
		ev(8);
		chk("chime", 32'h0, hit);
		wr(OFF_CFG0, 32'h00ca_00c0);
		ev(8);
		chk("chime", 32'h1, hit);
		close_out;
	end
endmodule
